// File: hdl/ptc_params.svh
// constants for the pulse train position command block
// Function
// - speed from pulse rate, distance from count
// - format select 0 split, 1 step, 4 quad
// - split lines: cw plus, ccw minus
// - step mode: cw level direction, ccw steps
// - quad x4: ccw phase A, cw phase B
// - resolution default 2621440, 0 means 5242880
// - divide internal resolution, carry remainder forward
// - grid points per turn anchored at home
// - first pulse snaps motor onto the grid
// - pulses before servo active are discarded
// - pulse activity forces arrived flag open
// - arrived after stop and settled window time
// - error under flag closes below threshold
// - signed 32 bit accepted pulse counter
// - angle monitors in resolution units, wrapping
// - format and resolution need valid password
// - arrived closed means positioned and held
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH
`define FMT_SPLIT   3'h0
`define FMT_STEP    3'h1
`define FMT_QUAD    3'h4
`define FMT_DEF     3'h0
`define CR_DEF      23'h280000
`define CR_ZERO_VAL 24'h500000
`define CR_MIN      23'h0003e8
`define CR_MAX      23'h4fffff
`define INT_RES     24'h280000
`define INT_HALF    22'h140000
`define Q0_RST      12'h001
`define CLK_NS      25
`define TICK_NS     100000
`define TICK_CYC    ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)
`define DIV_LAST    6'h2d
`endif

// File: hdl/ptc_pkg.sv
// types shared by the pulse train position command block
package ptc_pkg;
  typedef struct packed {
    logic [2:0]  fmt;
    logic [22:0] cr;
  } cfg_t;
  typedef struct packed {
    logic up;
    logic dn;
  } step_t;
  typedef enum logic {S_PICK, S_DIV} state_t;
  typedef enum logic [1:0] {J_STEP, J_MON, J_GRID} job_t;
endpackage

// File: hdl/pulse_train_position_command.sv
// pulse train command decoder, grid scaler and arrival logic
`timescale 1ns/1ps
`default_nettype none
`include "ptc_params.svh"
module pulse_train_position_command
  import ptc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               cw_pulse_input,
  input  wire logic               ccw_pulse_input,
  input  wire logic               servo_active,
  input  wire logic [2:0]         pulse_format_select,
  input  wire logic [22:0]        counts_per_turn,
  input  wire logic               cfg_write,
  input  wire logic               password_ok,
  input  wire logic [21:0]        actual_motor_pos,
  input  wire logic signed [31:0] position_error,
  input  wire logic [21:0]        in_position_window,
  input  wire logic [15:0]        stability_delay,
  input  wire logic [21:0]        error_threshold,
  output logic signed [23:0]      motor_step,
  output logic                    motor_step_valid,
  output logic                    arrived_flag,
  output logic                    error_under_flag,
  output logic signed [31:0]      input_pulse_count,
  output logic [22:0]             actual_angle_monitor,
  output logic [22:0]             commanded_angle_monitor,
  output cfg_t                    active_cfg,
  output logic                    grid_locked
);

  // ****************************************
  // helpers
  // ****************************************
  // bring a value in [0, 2*res) back into one turn
  function automatic logic [21:0] fold(input logic [24:0] v);
    logic [24:0] t;
    t = (v >= {1'b0, `INT_RES}) ? v - {1'b0, `INT_RES} : v;
    return t[21:0];
  endfunction

  function automatic logic [23:0] eff_res(input logic [22:0] c);
    return (c == 23'h0) ? `CR_ZERO_VAL : {1'b0, c};
  endfunction

  // ****************************************
  // configuration
  // ****************************************
  logic [3:0]  cfg_seq_reg;
  logic [3:0]  done_seq_reg;
  logic [3:0]  seq_lat_reg;
  logic        fmt_ok;
  logic        cr_ok;
  logic [23:0] cr_eff;
  logic        cfg_dirty;
  logic        cfg_take;

  assign fmt_ok = (pulse_format_select == `FMT_SPLIT) ||
                  (pulse_format_select == `FMT_STEP) ||
                  (pulse_format_select == `FMT_QUAD);
  assign cr_ok = (counts_per_turn == 23'h0) ||
                 (counts_per_turn >= `CR_MIN && counts_per_turn <= `CR_MAX);
  assign cr_eff = eff_res(active_cfg.cr);
  // a sequence number avoids a second driver on a dirty flag
  assign cfg_dirty = (cfg_seq_reg != done_seq_reg);
  assign cfg_take = cfg_write && password_ok && fmt_ok && cr_ok;

  // writes without the password or out of range are dropped
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_cfg  <= '{fmt: `FMT_DEF, cr: `CR_DEF};
      cfg_seq_reg <= 4'h0;
    end else if (cfg_take) begin
      active_cfg  <= '{fmt: pulse_format_select, cr: counts_per_turn};
      cfg_seq_reg <= cfg_seq_reg + 4'h1;
    end
  end

  // ****************************************
  // input synchroniser and decoder
  // ****************************************
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] rise;
  logic [1:0] edge_any;
  step_t      ev;

  // bit 1 is the cw line, bit 0 the ccw line
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
        end else begin
          pin_s1[gi] <= (gi == 1) ? cw_pulse_input : ccw_pulse_input;
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
        end
      end
    end
  endgenerate

  assign rise = pin_s2 & ~pin_s3;
  assign edge_any = pin_s2 ^ pin_s3;

  // one decoded count per cycle at most
  always_comb begin
    ev = '{up: 1'b0, dn: 1'b0};
    case (active_cfg.fmt)
      `FMT_SPLIT: begin
        ev.up = rise[1] & ~rise[0];
        ev.dn = rise[0] & ~rise[1];
      end
      `FMT_STEP: begin
        ev.up = rise[0] & ~pin_s2[1];
        ev.dn = rise[0] & pin_s2[1];
      end
      `FMT_QUAD: begin
        // a double change is a lost phase and is ignored
        if (edge_any[0] ^ edge_any[1]) begin
          ev.dn = pin_s3[0] ^ pin_s2[1];
          ev.up = ~(pin_s3[0] ^ pin_s2[1]);
        end
      end
      default: ev = '{up: 1'b0, dn: 1'b0};
    endcase
  end

  // accepted pulse counter, wraps at the signed limits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      input_pulse_count <= 32'sh0;
    end else if (servo_active) begin
      if (ev.up) begin
        input_pulse_count <= input_pulse_count + 32'sh1;
      end else if (ev.dn) begin
        input_pulse_count <= input_pulse_count - 32'sh1;
      end
    end
  end

  // ****************************************
  // shared divider and alignment sequencer
  // ****************************************
  state_t      state_reg;
  job_t        job_reg;
  logic [45:0] num_reg;
  logic [23:0] den_reg;
  logic [23:0] rem_reg;
  logic [5:0]  cnt_reg;
  logic [11:0] q0_reg;
  logic [23:0] r0_reg;
  logic [22:0] k_lat_reg;
  logic [21:0] p_lat_reg;
  logic [24:0] trial;
  logic        ge;
  logic [23:0] rem_next;
  logic [45:0] num_next;
  logic [45:0] mul_mon;
  logic [45:0] mul_grid;
  logic        last;
  logic        grid_load;

  assign trial = {rem_reg, num_reg[45]};
  assign ge = trial >= {1'b0, den_reg};
  assign rem_next = ge ? 24'(trial - {1'b0, den_reg}) : trial[23:0];
  assign num_next = {num_reg[44:0], ge};
  assign mul_mon = {24'h0, actual_motor_pos} * {22'h0, cr_eff};
  assign mul_grid = {23'h0, num_next[22:0]} * {22'h0, `INT_RES};
  assign last = (state_reg == S_DIV) && (cnt_reg == `DIV_LAST);
  assign grid_load = last && (job_reg == J_GRID) && servo_active && !cfg_dirty;

  // jobs: step size after a change, monitor refresh, grid snap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= S_PICK;
      job_reg <= J_MON;
      num_reg <= 46'h0;
      den_reg <= 24'h1;
      rem_reg <= 24'h0;
      cnt_reg <= 6'h0;
      q0_reg <= `Q0_RST;
      r0_reg <= 24'h0;
      done_seq_reg <= 4'h0;
      seq_lat_reg <= 4'h0;
      k_lat_reg <= 23'h0;
      p_lat_reg <= 22'h0;
      actual_angle_monitor <= 23'h0;
      grid_locked <= 1'b0;
    end else begin
      if (!servo_active || cfg_dirty) begin
        grid_locked <= 1'b0;
      end
      case (state_reg)
        S_PICK: begin
          rem_reg <= 24'h0;
          cnt_reg <= 6'h0;
          state_reg <= S_DIV;
          if (cfg_dirty) begin
            job_reg <= J_STEP;
            num_reg <= {22'h0, `INT_RES};
            den_reg <= cr_eff;
            seq_lat_reg <= cfg_seq_reg;
          end else begin
            job_reg <= J_MON;
            num_reg <= mul_mon;
            den_reg <= `INT_RES;
            p_lat_reg <= actual_motor_pos;
          end
        end
        S_DIV: begin
          num_reg <= num_next;
          rem_reg <= rem_next;
          cnt_reg <= cnt_reg + 6'h1;
          if (last) begin
            state_reg <= S_PICK;
            case (job_reg)
              J_STEP: begin
                q0_reg <= num_next[11:0];
                r0_reg <= rem_next;
                done_seq_reg <= seq_lat_reg;
              end
              J_MON: begin
                actual_angle_monitor <= num_next[22:0];
                // grid index below the shaft, anchored at home
                if (servo_active && !grid_locked && !cfg_dirty) begin
                  job_reg <= J_GRID;
                  k_lat_reg <= num_next[22:0];
                  num_reg <= mul_grid;
                  den_reg <= cr_eff;
                  rem_reg <= 24'h0;
                  cnt_reg <= 6'h0;
                  state_reg <= S_DIV;
                end
              end
              J_GRID: begin
                if (servo_active && !cfg_dirty) begin
                  grid_locked <= 1'b1;
                end
              end
              default: state_reg <= S_PICK;
            endcase
          end
        end
        default: state_reg <= S_PICK;
      endcase
    end
  end

  // ****************************************
  // command engine
  // ****************************************
  logic signed [15:0] pend_reg;
  logic [22:0]        k_reg;
  logic [21:0]        g_reg;
  logic [23:0]        r_reg;
  logic [21:0]        out_reg;
  logic               consume;
  logic               go_minus;
  logic [24:0]        r_up;
  logic               carry;
  logic               borrow;
  logic [23:0]        r_new;
  logic [21:0]        g_new;
  logic [22:0]        k_new;
  logic [21:0]        d_fold;
  logic signed [15:0] pend_in;

  // drained one count per cycle: far above the pulse rate limit
  // no step while the step size is recomputed: q0 and r0 would be stale
  assign consume = grid_locked && !cfg_dirty && (pend_reg != 16'sh0) && !grid_load;
  assign go_minus = pend_reg[15];
  assign pend_in = ev.up ? 16'sh1 : (ev.dn ? -16'sh1 : 16'sh0);

  // remainder carried between steps so no motion is lost
  always_comb begin
    r_up = {1'b0, r_reg} + {1'b0, r0_reg};
    carry = r_up >= {1'b0, cr_eff};
    borrow = r_reg < r0_reg;
    if (!go_minus) begin
      r_new = carry ? 24'(r_up - {1'b0, cr_eff}) : r_up[23:0];
      g_new = fold({3'h0, g_reg} + {13'h0, q0_reg} + {24'h0, carry});
      k_new = (k_reg == 23'(cr_eff - 24'h1)) ? 23'h0 : k_reg + 23'h1;
    end else begin
      r_new = borrow ? 24'(r_reg - r0_reg + cr_eff) : 24'(r_reg - r0_reg);
      g_new = fold({3'h0, g_reg} + {1'b0, `INT_RES} - {13'h0, q0_reg}
                   - {24'h0, borrow});
      k_new = (k_reg == 23'h0) ? 23'(cr_eff - 24'h1) : k_reg - 23'h1;
    end
    d_fold = fold({3'h0, g_new} + {1'b0, `INT_RES} - {3'h0, out_reg});
  end

  // first step is taken from the shaft, not from the grid
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_reg <= 16'sh0;
      k_reg <= 23'h0;
      g_reg <= 22'h0;
      r_reg <= 24'h0;
      out_reg <= 22'h0;
      motor_step <= 24'sh0;
      motor_step_valid <= 1'b0;
    end else begin
      motor_step_valid <= 1'b0;
      if (!servo_active) begin
        pend_reg <= 16'sh0;
      end else begin
        pend_reg <= pend_reg + pend_in - (consume ? (go_minus ? -16'sh1 : 16'sh1) : 16'sh0);
      end
      if (grid_load) begin
        k_reg <= k_lat_reg;
        g_reg <= num_next[21:0];
        r_reg <= rem_next;
        out_reg <= p_lat_reg;
      end else if (consume) begin
        k_reg <= k_new;
        g_reg <= g_new;
        r_reg <= r_new;
        out_reg <= g_new;
        motor_step_valid <= 1'b1;
        motor_step <= (d_fold > `INT_HALF) ? 24'({2'h0, d_fold}) - 24'(`INT_RES)
                                           : 24'({2'h0, d_fold});
      end
      // a new resolution restarts the index so the monitor stays in range
      if (cfg_take) begin
        k_reg <= 23'h0;
      end
    end
  end

  assign commanded_angle_monitor = k_reg;

  // ****************************************
  // arrival and error under threshold
  // ****************************************
  logic [11:0] tick_reg;
  logic        tick;
  logic [15:0] settle_reg;
  logic [31:0] abs_err;
  logic        in_win;
  logic        busy;

  assign tick = (tick_reg == 12'(`TICK_CYC - 1));
  assign abs_err = position_error[31] ? 32'(-position_error) : position_error;
  assign in_win = abs_err <= {10'h0, in_position_window};
  assign busy = (|edge_any) || (pend_reg != 16'sh0);

  // 0.1 ms enable for the settling timer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_reg <= 12'h0;
    end else begin
      tick_reg <= tick ? 12'h0 : tick_reg + 12'h1;
    end
  end

  // a pause longer than the settling time reads as arrival
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      settle_reg <= 16'h0;
      arrived_flag <= 1'b0;
    end else if (busy || !in_win || !servo_active) begin
      settle_reg <= 16'h0;
      arrived_flag <= 1'b0;
    end else if (settle_reg >= stability_delay) begin
      arrived_flag <= 1'b1;
    end else if (tick) begin
      settle_reg <= settle_reg + 16'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      error_under_flag <= 1'b0;
    end else begin
      error_under_flag <= abs_err < {10'h0, error_threshold};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_drop_before_on: assert property (
    !servo_active |=> $stable(input_pulse_count))
    else $error("count moved without servo");
  a_activity_opens: assert property (
    (|edge_any) |=> !arrived_flag)
    else $error("arrived while pulses active");
  a_arrive_settled: assert property (
    $rose(arrived_flag) |-> $past(in_win) && !$past(busy))
    else $error("arrived without settling");
  a_under_level: assert property (
    ##1 error_under_flag == ($past(abs_err) < {10'h0, $past(error_threshold)}))
    else $error("error under flag wrong");
  a_cfg_locked: assert property (
    !password_ok |=> $stable(active_cfg))
    else $error("config changed without password");
  a_split_plus: assert property (
    (servo_active && active_cfg.fmt == `FMT_SPLIT && rise == 2'b10)
    |=> input_pulse_count == $past(input_pulse_count) + 32'sh1)
    else $error("cw pulse not counted up");
  a_step_minus: assert property (
    (servo_active && active_cfg.fmt == `FMT_STEP && rise[0] && pin_s2[1])
    |=> input_pulse_count == $past(input_pulse_count) - 32'sh1)
    else $error("step with direction not counted down");
  a_quad_edge: assert property (
    (servo_active && active_cfg.fmt == `FMT_QUAD && edge_any == 2'b01)
    |=> input_pulse_count != $past(input_pulse_count))
    else $error("quadrature edge not counted");
  a_grid_wrap: assert property (
    {1'b0, commanded_angle_monitor} < cr_eff)
    else $error("commanded angle out of range");

endmodule
`default_nettype wire

// File: verif/pulse_source.sv
// behavioural motion controller that drives the command pulse lines
`timescale 1ns/1ps
`default_nettype none
module pulse_source #(
  parameter int HOLD = 20
) (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [2:0] fmt,
  input  wire logic       minus,
  input  wire logic [7:0] n,
  output logic            busy,
  output logic            cw_pulse_input,
  output logic            ccw_pulse_input
);
  // ****************************************
  // frame generator
  // ****************************************
  logic [1:0] phase;

  // every level held HOLD cycles; 20 keeps a line at 1 Mpps at 40 MHz
  task automatic hold();
    repeat (HOLD) @(posedge clk);
    #2;
  endtask

  // one frame per go request: n steps in the asked format and direction
  initial begin
    busy = 1'b0;
    cw_pulse_input = 1'b0;
    ccw_pulse_input = 1'b0;
    phase = 2'h0;
    forever begin
      @(posedge clk iff go);
      #2;
      busy = 1'b1;
      if (fmt == 3'h1) begin
        cw_pulse_input = minus;
        hold();
      end
      repeat (n) begin
        if (fmt == 3'h4) begin
          phase = minus ? phase - 2'h1 : phase + 2'h1;
          ccw_pulse_input = phase[1] ^ phase[0];
          cw_pulse_input = phase[1];
        end else if (fmt == 3'h0 && !minus) begin
          cw_pulse_input = 1'b1;
          hold();
          cw_pulse_input = 1'b0;
        end else begin
          ccw_pulse_input = 1'b1;
          hold();
          ccw_pulse_input = 1'b0;
        end
        // gaps stay far below 0.1 ms, so settling cannot fire mid-frame
        hold();
      end
      if (fmt == 3'h1) cw_pulse_input = 1'b0;
      busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_pulse_train_position_command.sv
// self-checking bench for the pulse train position command block
`timescale 1ns/1ps
`default_nettype none
module tb_pulse_train_position_command
  import ptc_pkg::*;
  ;
  logic               clk, sys_rst, cw_pulse_input, ccw_pulse_input, servo_active;
  logic               cfg_write, password_ok, go, minus, busy;
  logic               motor_step_valid, arrived_flag, error_under_flag, grid_locked;
  logic [2:0]         pulse_format_select, mfmt;
  logic [7:0]         n;
  logic [22:0]        counts_per_turn, actual_angle_monitor, commanded_angle_monitor;
  logic [21:0]        actual_motor_pos, in_position_window, error_threshold;
  logic [15:0]        stability_delay;
  logic signed [31:0] position_error, input_pulse_count, step_sum;
  logic signed [23:0] motor_step;
  cfg_t               active_cfg;
  int                 bad_count, compares;

  pulse_train_position_command pulse_train_position_command_i (
    .clk(clk), .sys_rst(sys_rst), .cw_pulse_input(cw_pulse_input),
    .ccw_pulse_input(ccw_pulse_input), .servo_active(servo_active),
    .pulse_format_select(pulse_format_select), .counts_per_turn(counts_per_turn),
    .cfg_write(cfg_write), .password_ok(password_ok), .actual_motor_pos(actual_motor_pos),
    .position_error(position_error), .in_position_window(in_position_window),
    .stability_delay(stability_delay), .error_threshold(error_threshold),
    .motor_step(motor_step), .motor_step_valid(motor_step_valid),
    .arrived_flag(arrived_flag), .error_under_flag(error_under_flag),
    .input_pulse_count(input_pulse_count), .actual_angle_monitor(actual_angle_monitor),
    .commanded_angle_monitor(commanded_angle_monitor), .active_cfg(active_cfg),
    .grid_locked(grid_locked));

  pulse_source pulse_source_i (
    .clk(clk), .go(go), .fmt(mfmt), .minus(minus), .n(n), .busy(busy),
    .cw_pulse_input(cw_pulse_input), .ccw_pulse_input(ccw_pulse_input));

  // ****************************************
  // clock, step sum and helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // sum of issued increments; tests clear it off the edge
  always @(posedge clk) if (motor_step_valid === 1'b1) step_sum <= step_sum + motor_step;

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #2;
  endtask

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // write format and resolution together, then compare the active settings
  task automatic cfg_case(input logic [2:0] f, input logic [22:0] r, input logic pw,
                          input logic [31:0] exp);
    pulse_format_select = f;
    counts_per_turn = r;
    password_ok = pw;
    cfg_write = 1'b1;
    tick(1);
    cfg_write = 1'b0;
    tick(1);
    check_word("active_cfg", exp, {6'h0, active_cfg});
  endtask

  task automatic start(input logic [2:0] f, input logic m, input logic [7:0] cnt);
    mfmt = f;
    minus = m;
    n = cnt;
    go = 1'b1;
    tick(2);
    go = 1'b0;
  endtask

  // bounded wait for the frame, then time for sync delay and backlog drain
  task automatic finish();
    for (int i = 0; i < 4000 && busy === 1'b1; i++) tick(1);
    check_bit("frame_done", 1'b0, busy);
    tick(40);
  endtask

  task automatic send(input logic [2:0] f, input logic m, input logic [7:0] cnt);
    start(f, m, cnt);
    finish();
  endtask

  task automatic wait_lock();
    for (int i = 0; i < 600 && grid_locked !== 1'b1; i++) tick(1);
    check_bit("grid_locked", 1'b1, grid_locked);
    step_sum = 32'sh0;
  endtask

  task automatic err_case(input logic [21:0] thr, input logic signed [31:0] e, input logic exp);
    error_threshold = thr;
    position_error = e;
    tick(3);
    check_bit("error_under", exp, error_under_flag);
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog: the tests need about 8000 cycles, this allows 60000
  initial begin
    #1_500_000;
    bad_count++;
    stop_test();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    {servo_active, cfg_write, password_ok, go, minus} = 5'h00;
    {pulse_format_select, mfmt, n} = 14'h0000;
    counts_per_turn = 23'h0;
    actual_motor_pos = 22'h3;
    in_position_window = 22'ha;
    stability_delay = 16'h2;
    error_threshold = 22'h0;
    position_error = 32'sh0;
    step_sum = 32'sh0;
    bad_count = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    #2 sys_rst = 1'b0;
    tick(1);
    check_word("active_cfg", 32'h0028_0000, {6'h0, active_cfg});
    check_word("pulse_count", 32'h0, input_pulse_count);
    check_bit("arrived", 1'b0, arrived_flag);
    $display("test reset done");
    // refused writes first, then each format and boundary resolution
    cfg_case(3'h1, 23'h050000, 1'b0, 32'h0028_0000);
    cfg_case(3'h2, 23'h050000, 1'b1, 32'h0028_0000);
    cfg_case(3'h0, 23'h0003e7, 1'b1, 32'h0028_0000);
    cfg_case(3'h0, 23'h500000, 1'b1, 32'h0028_0000);
    cfg_case(3'h0, 23'h000000, 1'b1, 32'h0000_0000);
    cfg_case(3'h1, 23'h0003e8, 1'b1, 32'h0080_03e8);
    cfg_case(3'h4, 23'h4fffff, 1'b1, 32'h024f_ffff);
    cfg_case(3'h0, 23'h050000, 1'b1, 32'h0005_0000);
    $display("test config done");
    send(3'h0, 1'b0, 8'h3);
    check_word("pulse_count", 32'h0, input_pulse_count);
    $display("test servo off done");
    // shaft 3 counts above home, 8 internal counts per grid step
    servo_active = 1'b1;
    wait_lock();
    send(3'h0, 1'b0, 8'h3);
    check_word("pulse_count", 32'h3, input_pulse_count);
    check_word("step_sum", 32'h15, step_sum);
    check_word("cmd_angle", 32'h3, {9'h0, commanded_angle_monitor});
    servo_active = 1'b0;
    tick(4);
    servo_active = 1'b1;
    wait_lock();
    send(3'h0, 1'b1, 8'h2);
    check_word("pulse_count", 32'h1, input_pulse_count);
    check_word("step_sum", 32'hffff_ffed, step_sum);
    check_word("cmd_angle", 32'h4fffe, {9'h0, commanded_angle_monitor});
    $display("test split done");
    cfg_case(3'h1, 23'h050000, 1'b1, 32'h0085_0000);
    send(3'h1, 1'b1, 8'h4);
    check_word("pulse_count", 32'hffff_fffd, input_pulse_count);
    send(3'h1, 1'b0, 8'h2);
    check_word("pulse_count", 32'hffff_ffff, input_pulse_count);
    $display("test step dir done");
    cfg_case(3'h4, 23'h050000, 1'b1, 32'h0205_0000);
    send(3'h4, 1'b0, 8'h8);
    check_word("pulse_count", 32'h7, input_pulse_count);
    send(3'h4, 1'b1, 8'h4);
    check_word("pulse_count", 32'h3, input_pulse_count);
    $display("test quadrature done");
    actual_motor_pos = 22'h320;
    tick(200);
    check_word("act_angle", 32'h64, {9'h0, actual_angle_monitor});
    $display("test angle done");
    err_case(22'h0, 32'sh0, 1'b0);
    err_case(22'h32, -32'sd49, 1'b1);
    err_case(22'h32, 32'sd50, 1'b0);
    err_case(22'h32, 32'sd0, 1'b1);
    $display("test error under done");
    // settling of two ticks of 4000 cycles after the last pulse
    send(3'h4, 1'b0, 8'h4);
    check_bit("arrived", 1'b0, arrived_flag);
    tick(2900);
    check_bit("arrived", 1'b0, arrived_flag);
    for (int i = 0; i < 9000 && arrived_flag !== 1'b1; i++) tick(1);
    check_bit("arrived", 1'b1, arrived_flag);
    start(3'h4, 1'b0, 8'h4);
    tick(15);
    check_bit("arrived", 1'b0, arrived_flag);
    finish();
    check_word("pulse_count", 32'hb, input_pulse_count);
    $display("test arrival done");
    stop_test();
  end
endmodule
`default_nettype wire
